// file: shared/err_record_pkg.sv
/*
  Constants and carrier types for the error record feature and syndrome
  block: register offsets, capability field positions, access view codes.
  Assumes a single synchronous clock domain and 64-bit register data.
*/
package err_record_pkg;

  // ==========================================================================
  // Memory-mapped layout
  localparam logic [5:0] OFS_FEATURES = 6'h00;
  localparam logic [5:0] OFS_MISC0 = 6'h20;
  localparam int REC_STRIDE_LOG2 = 6;

  // ==========================================================================
  // Capability field positions
  localparam int FR_RP = 15;
  localparam int FR_CEC_LO = 12;
  localparam int FR_CFI_LO = 10;
  localparam int FR_UE_LO = 8;
  localparam int FR_FI_LO = 6;
  localparam int FR_UI_LO = 4;
  localparam int FR_IMP_LO = 2;
  localparam int FR_ED_LO = 0;

  localparam logic [2:0] CEC_NONE = 3'h0;
  localparam logic [2:0] CEC_8BIT = 3'h2;
  localparam logic [2:0] CEC_16BIT = 3'h4;
  localparam logic [1:0] SUP_NONE = 2'h0;
  localparam logic [1:0] SUP_ALWAYS = 2'h1;
  localparam logic [1:0] SUP_ONE_BIT = 2'h2;
  localparam logic [1:0] SUP_SPLIT = 2'h3;

  // ==========================================================================
  // Select window views
  localparam logic [2:0] VIEW_SELECT = 3'h0;
  localparam logic [2:0] VIEW_MISC_LOW = 3'h1;
  localparam logic [2:0] VIEW_MISC_HIGH = 3'h2;
  localparam logic [2:0] VIEW_MISC_FULL = 3'h3;
  localparam logic [2:0] VIEW_FEATURES = 3'h4;

  localparam logic [63:0] MISC0_RESET = 64'h0;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [63:0] wdata;
  } mm_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [2:0] view;
    logic [63:0] wdata;
  } sel_req_t;

endpackage

// file: core/err_record_bank.sv
/*
  Error record bank: per-node capability register and per-record first
  syndrome register with standard corrected error counters, reached by a
  memory-mapped port and by a selected-record window.
  Assumes inputs synchronous to clk_sys and one request per port per cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module err_record_bank
  import err_record_pkg::*;
#(
  // Number of error records held by this bank.
  parameter int NREC = 4,
  // Records owned by each node; the lowest of each group heads the node.
  parameter int REC_PER_NODE = 2,
  // One bit per record: the record exists in hardware.
  parameter logic [NREC-1:0] IMPL_MASK = '1,
  // One bit per record: the record can count corrected errors.
  parameter logic [NREC-1:0] COUNT_MASK = '1,
  // Standard counter format reported by every implemented node head.
  parameter logic [2:0] CEC_FMT = CEC_16BIT,
  // Second counter beside the corrected counter.
  parameter logic RP_OPT = 1'b0,
  // Control style of fault interrupts on corrected errors.
  parameter logic [1:0] CFI_SUP = SUP_ONE_BIT,
  // Support level of the in-band error response.
  parameter logic [1:0] UE_SUP = SUP_ALWAYS,
  // Support level of the fault handling interrupt.
  parameter logic [1:0] FI_SUP = SUP_ONE_BIT,
  // Support level of the error recovery interrupt.
  parameter logic [1:0] UI_SUP = SUP_SPLIT,
  // Free value returned in capability bits 3 and 2.
  parameter logic [1:0] IMP_BITS = 2'h0,
  // Logging control style of the node head.
  parameter logic [1:0] ED_SUP = SUP_ONE_BIT,
  // Deferred errors not deferred to the requester answer in band.
  parameter logic DEFER_INBAND = 1'b0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Memory-mapped port, answered one cycle after each request.
  input wire mm_req_t mm_in,
  output logic mm_ack,
  output logic [63:0] mm_rdata,
  // Selected-record window, answered one cycle after each request.
  input wire sel_req_t sel_in,
  output logic sel_ack,
  output logic [63:0] sel_rdata,
  // Countable error events, one count per high cycle.
  input wire logic [NREC-1:0] ce_event,
  input wire logic [NREC-1:0] ce_repeat,
  // Overflow requests and fixed capability outputs.
  output logic [NREC-1:0] fault_req,
  output logic [7:0] ctl_enable_allowed,
  output logic inband_on_deferred
);

  // ==========================================================================
  // Capability value
  function automatic logic [1:0] cfi_field();
    return (FI_SUP == SUP_NONE) ? SUP_NONE : CFI_SUP;
  endfunction

  function automatic logic [63:0] fr_value();
    logic [63:0] v;
    v = 64'h0;
    v[FR_RP] = (CEC_FMT == CEC_NONE) ? 1'b0 : RP_OPT;
    v[FR_CEC_LO +: 3] = CEC_FMT;
    v[FR_CFI_LO +: 2] = cfi_field();
    v[FR_UE_LO +: 2] = UE_SUP;
    v[FR_FI_LO +: 2] = FI_SUP;
    v[FR_UI_LO +: 2] = UI_SUP;
    v[FR_IMP_LO +: 2] = IMP_BITS;
    v[FR_ED_LO +: 2] = ED_SUP;
    return v;
  endfunction

  localparam logic [63:0] FR_CONST = fr_value();

  // A feature that is absent or always on has no live enable bits.
  function automatic logic [1:0] enables(input logic [1:0] sup);
    case (sup)
      SUP_ONE_BIT: return 2'h1;
      SUP_SPLIT: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // Enable bits per feature: {recovery, fault, in-band, corrected fault}.
  assign ctl_enable_allowed = {enables(UI_SUP), enables(FI_SUP),
                               enables(UE_SUP), enables(cfi_field())};
  assign inband_on_deferred = DEFER_INBAND;

  // ==========================================================================
  // Counter layout
  function automatic logic [63:0] cnt_mask();
    logic [63:0] m;
    m = 64'h0;
    case ({CEC_FMT, RP_OPT})
      {CEC_8BIT, 1'b0}: m[39:32] = 8'hff;
      {CEC_16BIT, 1'b0}: m[47:32] = 16'hffff;
      {CEC_8BIT, 1'b1}: m[47:32] = 16'hffff;
      {CEC_16BIT, 1'b1}: m[63:32] = 32'hffffffff;
      default: m = 64'h0;
    endcase
    return m;
  endfunction

  function automatic logic [63:0] of_mask();
    logic [63:0] m;
    m = 64'h0;
    case ({CEC_FMT, RP_OPT})
      {CEC_8BIT, 1'b0}: m[39] = 1'b1;
      {CEC_16BIT, 1'b0}: m[47] = 1'b1;
      {CEC_8BIT, 1'b1}: m = 64'h0000_8080_0000_0000;
      {CEC_16BIT, 1'b1}: m = 64'h8000_8000_0000_0000;
      default: m = 64'h0;
    endcase
    return m;
  endfunction

  // Bits that belong to counters, and the sticky overflow bits among them.
  // A non-counting record hides the first set; only the second set can
  // raise a fault request.
  localparam logic [63:0] CNT_MASK = cnt_mask();
  localparam logic [63:0] OF_MASK = of_mask();

  // Counter with a sticky overflow bit on top that sets on wrap.
  function automatic logic [15:0] bump16(input logic [15:0] f);
    return {f[15] | (&f[14:0]), f[14:0] + 15'h1};
  endfunction

  function automatic logic [7:0] bump8(input logic [7:0] f);
    return {f[7] | (&f[6:0]), f[6:0] + 7'h1};
  endfunction

  function automatic logic [63:0] count_step(input logic [63:0] m,
                                             input logic rep);
    logic [63:0] r;
    r = m;
    case ({CEC_FMT, RP_OPT})
      {CEC_8BIT, 1'b0}: r[39:32] = bump8(m[39:32]);
      {CEC_16BIT, 1'b0}: r[47:32] = bump16(m[47:32]);
      {CEC_8BIT, 1'b1}: begin
        if (rep) begin
          r[39:32] = bump8(m[39:32]);
        end else begin
          r[47:40] = bump8(m[47:40]);
        end
      end
      {CEC_16BIT, 1'b1}: begin
        if (rep) begin
          r[47:32] = bump16(m[47:32]);
        end else begin
          r[63:48] = bump16(m[63:48]);
        end
      end
      default: r = m;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Address decode
  localparam int IDX_W = 12 - REC_STRIDE_LOG2;
  localparam int SEL_W = (NREC > 1) ? $clog2(NREC) : 1;

  // One syndrome word per record; the window index keeps the full index
  // width so that out-of-range selections read as zero.
  logic [63:0] misc_q [NREC];
  logic [IDX_W-1:0] sel_idx_q;

  wire [IDX_W-1:0] mm_idx = mm_in.addr[11:REC_STRIDE_LOG2];
  wire [5:0] mm_ofs = mm_in.addr[REC_STRIDE_LOG2-1:0];
  wire mm_is_fr = (mm_ofs == OFS_FEATURES);
  wire mm_is_misc = (mm_ofs == OFS_MISC0);
  wire mm_in_range = (mm_idx < IDX_W'(NREC));
  wire sel_in_range = (sel_idx_q < IDX_W'(NREC));
  wire [SEL_W-1:0] mm_rec = SEL_W'(mm_idx);
  wire [SEL_W-1:0] sel_rec = SEL_W'(sel_idx_q);

  // Record features come from the first record of the node.
  function automatic logic [63:0] fr_read(input int idx);
    if ((idx % REC_PER_NODE) == 0 && IMPL_MASK[idx]) begin
      return FR_CONST;
    end
    return 64'h0;
  endfunction

  function automatic logic [63:0] misc_read(input logic [63:0] v,
                                            input int idx);
    if (!IMPL_MASK[idx]) begin
      return 64'h0;
    end
    return COUNT_MASK[idx] ? v : (v & ~CNT_MASK);
  endfunction

  wire [63:0] mm_misc_rd = mm_in_range ?
                           misc_read(misc_q[mm_rec], int'(mm_rec)) : 64'h0;
  wire [63:0] mm_fr_rd = mm_in_range ? fr_read(int'(mm_rec)) : 64'h0;
  wire [63:0] mm_rd_d = mm_is_misc ? mm_misc_rd :
                        (mm_is_fr ? mm_fr_rd : 64'h0);

  wire [63:0] sel_misc = sel_in_range ?
                         misc_read(misc_q[sel_rec], int'(sel_rec)) : 64'h0;
  wire [63:0] sel_fr = sel_in_range ? fr_read(int'(sel_rec)) : 64'h0;
  logic [63:0] sel_rd_d;
  always_comb begin
    case (sel_in.view)
      VIEW_SELECT: sel_rd_d = 64'(sel_idx_q);
      VIEW_MISC_LOW: sel_rd_d = {32'h0, sel_misc[31:0]};
      VIEW_MISC_HIGH: sel_rd_d = {32'h0, sel_misc[63:32]};
      VIEW_MISC_FULL: sel_rd_d = sel_misc;
      VIEW_FEATURES: sel_rd_d = sel_fr;
      default: sel_rd_d = 64'h0;
    endcase
  end

  // Writes to the capability offset, to unmapped offsets and to absent
  // records fall through here and are still acknowledged.
  wire mm_misc_wr = mm_in.req && mm_in.we && mm_is_misc && mm_in_range;
  wire sel_misc_wr = sel_in.req && sel_in.we && sel_in_range &&
                     (sel_in.view == VIEW_MISC_LOW ||
                      sel_in.view == VIEW_MISC_HIGH ||
                      sel_in.view == VIEW_MISC_FULL);
  wire sel_idx_wr = sel_in.req && sel_in.we && (sel_in.view == VIEW_SELECT);

  // ==========================================================================
  // Per-record syndrome storage
  for (genvar n = 0; n < NREC; n++) begin : g_rec
    localparam logic CNT_EN = IMPL_MASK[n] & COUNT_MASK[n];
    wire hit_mm = mm_misc_wr && (mm_rec == SEL_W'(n));
    wire hit_sel = sel_misc_wr && (sel_rec == SEL_W'(n)) && !hit_mm;
    logic [63:0] wr_val;
    logic [63:0] base;
    logic [63:0] misc_d;
    always_comb begin
      case (sel_in.view)
        VIEW_MISC_LOW: wr_val = {misc_q[n][63:32], sel_in.wdata[31:0]};
        VIEW_MISC_HIGH: wr_val = {sel_in.wdata[31:0], misc_q[n][31:0]};
        default: wr_val = sel_in.wdata;
      endcase
      // Writing zero clears counters and overflow, dropping the request.
      base = hit_mm ? mm_in.wdata : (hit_sel ? wr_val : misc_q[n]);
      // A count arriving with a write lands on the written value.
      misc_d = (ce_event[n] && CNT_EN) ? count_step(base, ce_repeat[n]) : base;
      if (!IMPL_MASK[n]) begin
        misc_d = 64'h0;
      end else if (!CNT_EN) begin
        misc_d = misc_d & ~CNT_MASK;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        misc_q[n] <= MISC0_RESET;
      end else begin
        misc_q[n] <= misc_d;
      end
    end

    // Only a counting record can raise a fault request, from overflow.
    assign fault_req[n] = CNT_EN && |(misc_q[n] & OF_MASK);
  end

  // ==========================================================================
  // Bus answers
  // Every request is acknowledged one cycle later whatever it hit.
  // Read data is zero on writes and idle cycles, so a stale word never
  // appears beside an acknowledge.
  // A new window index applies from the request after the one that wrote it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_idx_q <= '0;
      mm_ack <= 1'b0;
      mm_rdata <= 64'h0;
      sel_ack <= 1'b0;
      sel_rdata <= 64'h0;
    end else begin
      if (sel_idx_wr) begin
        sel_idx_q <= sel_in.wdata[IDX_W-1:0];
      end
      mm_ack <= mm_in.req;
      mm_rdata <= (mm_in.req && !mm_in.we) ? mm_rd_d : 64'h0;
      sel_ack <= sel_in.req;
      sel_rdata <= (sel_in.req && !sel_in.we) ? sel_rd_d : 64'h0;
    end
  end

endmodule

`default_nettype wire

// file: test/err_record_assertions.sv
/*
  Port checker for the error record bank, bound into every instance.
  Assumes the bank's default build parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module err_record_checker
  import err_record_pkg::*;
#(
  parameter int NREC = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire mm_req_t mm_in,
  input wire logic mm_ack,
  input wire logic [63:0] mm_rdata,
  input wire sel_req_t sel_in,
  input wire logic sel_ack,
  input wire logic [63:0] sel_rdata,
  input wire logic [NREC-1:0] ce_event,
  input wire logic [NREC-1:0] ce_repeat,
  input wire logic [NREC-1:0] fault_req,
  input wire logic [7:0] ctl_enable_allowed,
  input wire logic inband_on_deferred
);
  // ==========================================================================
  // Port relations
  localparam logic [63:0] CAP_HEAD = 64'h49b2;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  mm_answer_a: assert property (mm_in.req |=> mm_ack)
    else $error("memory port request not acknowledged");
  sel_answer_a: assert property (sel_in.req |=> sel_ack)
    else $error("window request not acknowledged");
  cap_head_a: assert property (mm_in.req && !mm_in.we &&
    mm_in.addr == 12'h000 |=> mm_rdata == CAP_HEAD)
    else $error("capability of first record wrong");
  misc_readback_a: assert property (mm_in.req && mm_in.we &&
    mm_in.addr == 12'h020 && !ce_event[0] ##1 mm_in.req && !mm_in.we &&
    mm_in.addr == 12'h020 |=> mm_rdata == $past(mm_in.wdata, 2))
    else $error("syndrome read differs from write");
  fault_withdraw_a: assert property (mm_in.req && mm_in.we &&
    mm_in.addr == 12'h020 && mm_in.wdata == 64'h0 && !ce_event[0]
    |=> !fault_req[0])
    else $error("zero write left request active");
  fault_cause_a: assert property ($rose(fault_req[0]) |->
    $past(ce_event[0] || mm_in.we || sel_in.we))
    else $error("request raised without cause");
  reset_quiet_a: assert property ($fell(srst) |->
    fault_req == '0 && !mm_ack && !sel_ack)
    else $error("bank not quiet after reset");
  fixed_outs_a: assert property (ctl_enable_allowed == 8'hd1 &&
    !inband_on_deferred)
    else $error("fixed control outputs wrong");
  mm_write_c: cover property (mm_in.req && mm_in.we);
  sel_read_c: cover property (sel_in.req && !sel_in.we);
  fault_c: cover property ($rose(fault_req[0]));
endmodule
bind err_record_bank err_record_checker #(.NREC(NREC)) chk (
  .clk_sys(clk_sys), .srst(srst), .mm_in(mm_in), .mm_ack(mm_ack),
  .mm_rdata(mm_rdata), .sel_in(sel_in), .sel_ack(sel_ack),
  .sel_rdata(sel_rdata), .ce_event(ce_event), .ce_repeat(ce_repeat),
  .fault_req(fault_req), .ctl_enable_allowed(ctl_enable_allowed),
  .inband_on_deferred(inband_on_deferred));
`default_nettype wire

// file: test/test_error_record_feature_and_misc0.sv
/*
  Self-checking bench for the error record bank.
  Assumes the bank's default build parameters and its checker bound in.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_error_record_feature_and_misc0
  import err_record_pkg::*;
();
  // ==========================================================================
  // Stimulus and scoreboard
  localparam logic [63:0] CAP_HEAD = 64'h49b2;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  mm_req_t mm_in = '0;
  sel_req_t sel_in = '0;
  logic [3:0] ce_event = 4'h0;
  logic mm_ack;
  logic sel_ack;
  logic [63:0] mm_rdata;
  logic [63:0] sel_rdata;
  logic [63:0] x;
  logic [3:0] fault_req;
  logic [7:0] ctl_enable_allowed;
  logic inband_on_deferred;
  logic [15:0] seed = 16'hef6d;
  logic [63:0] expq[$];
  int n_fail = 0;
  int checked = 0;

  err_record_bank DUT (.clk_sys(clk_sys), .srst(srst), .mm_in(mm_in),
    .mm_ack(mm_ack), .mm_rdata(mm_rdata), .sel_in(sel_in),
    .sel_ack(sel_ack), .sel_rdata(sel_rdata), .ce_event(ce_event),
    .ce_repeat(4'h0), .fault_req(fault_req),
    .ctl_enable_allowed(ctl_enable_allowed),
    .inband_on_deferred(inband_on_deferred));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [63:0] v);
    repeat (4) begin
      seed = lfsr(seed);
      v = {v[47:0], seed};
    end
  endtask

  // One request per cycle; consecutive calls run back to back.
  task automatic xfer(input bit sel, input bit we, input logic [11:0] a,
      input logic [63:0] d, input logic [63:0] e);
    mm_in <= '{!sel, we, a, d};
    sel_in <= '{sel, we, a[2:0], d};
    expq.push_back(e);
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    mm_in.req <= 1'h0;
    sel_in.req <= 1'h0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial forever #20 clk_sys = ~clk_sys;

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  always @(negedge clk_sys) begin
    if (mm_ack === 1'h1 || sel_ack === 1'h1) begin
      x = expq.pop_front();
      `CHK(mm_ack ? mm_rdata : sel_rdata, x)
    end
  end

  initial begin
    logic [63:0] v;
    logic [63:0] w;
    repeat (5) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    `CHK(ctl_enable_allowed, 8'hd1)
    `CHK(inband_on_deferred, 1'h0)
    for (int i = 0; i < 5; i++) begin
      xfer(0, 0, 12'h020 + 12'(i * 64), 64'h0, 64'h0);
      xfer(0, 0, 12'(i * 64), 64'h0,
        (i % 2 == 0 && i < 4) ? CAP_HEAD : 64'h0);
    end
    rnd(v);
    xfer(0, 1, 12'h000, v, 64'h0);
    xfer(0, 0, 12'h000, 64'h0, CAP_HEAD);
    xfer(0, 1, 12'h020, v, 64'h0);
    xfer(0, 0, 12'h020, 64'h0, v);
    xfer(0, 0, 12'h008, 64'h0, 64'h0);
    w = {v[63:48], 1'h0, 15'h7fff, v[31:0]};
    xfer(0, 1, 12'h020, w, 64'h0);
    idle(1);
    ce_event <= 4'h1;
    @(posedge clk_sys);
    ce_event <= 4'h0;
    @(negedge clk_sys);
    `CHK(fault_req, 4'h1)
    @(posedge clk_sys);
    xfer(0, 0, 12'h020, 64'h0, {v[63:48], 1'h1, 15'h0, v[31:0]});
    xfer(0, 1, 12'h020, 64'h0, 64'h0);
    idle(1);
    @(negedge clk_sys);
    `CHK(fault_req, 4'h0)
    @(posedge clk_sys);
    rnd(v);
    xfer(1, 1, VIEW_SELECT, 64'h1, 64'h0);
    xfer(1, 1, VIEW_MISC_LOW, v, 64'h0);
    xfer(1, 1, VIEW_MISC_HIGH, {32'h0, v[63:32]}, 64'h0);
    xfer(1, 0, VIEW_MISC_LOW, 64'h0, {32'h0, v[31:0]});
    xfer(1, 0, VIEW_MISC_HIGH, 64'h0, {32'h0, v[63:32]});
    xfer(1, 0, VIEW_MISC_FULL, 64'h0, v);
    xfer(0, 0, 12'h060, 64'h0, v);
    xfer(1, 1, VIEW_SELECT, 64'h2, 64'h0);
    xfer(1, 0, VIEW_FEATURES, 64'h0, CAP_HEAD);
    idle(3);
    `CHK(expq.size(), 0)
    results();
  end
endmodule
`default_nettype wire
